/* sim/gist_gfx_model.sv */
// graphics controller model: pixel clock and sync pulses on the pins
`timescale 1ns/1ps
module gist_gfx_model (
  output logic       o_pixel_clock,
  output logic [2:0] o_sync
);
  // pixel clock runs free, phase unrelated to the system clock
  initial begin
    o_pixel_clock = 1'b0;
    o_sync = 3'b000;
    #7;
    forever #160 o_pixel_clock = ~o_pixel_clock;
  end
  // a pulse leaves idle and returns: one used edge whatever the polarity
  task pulse(input int k);
    @(posedge o_pixel_clock);
    o_sync[k] <= ~o_sync[k];
    repeat (2) @(posedge o_pixel_clock);
    o_sync[k] <= ~o_sync[k];
    repeat (2) @(posedge o_pixel_clock);
  endtask
  task idle(input int k, input logic v);
    @(posedge o_pixel_clock);
    o_sync[k] <= v;
    repeat (2) @(posedge o_pixel_clock);
  endtask
endmodule // gist_gfx_model

/* sim/gist_top_assertions.sv */
// checker: register readback, role status and sync pin enables
`timescale 1ns/1ps
module gist_top_checker (
  input wire       I_CLK,
  input wire       I_RESET_N,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire       I_WR,
  input wire       I_RD,
  input wire [7:0] O_RDATA,
  input wire       O_HSYNC_PIN_OE,
  input wire       O_VSYNC_PIN_OE,
  input wire       O_FRAME_SYNC_PIN_OE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  reg  slave_reg;
  wire wr_sc = I_WR && I_ADDR == 8'h97;
  always @(posedge I_CLK) begin
    if (!I_RESET_N)
      slave_reg <= 1'b0;
    else if (I_WR && I_ADDR == 8'h96)
      slave_reg <= I_WDATA[5];
  end
  property p_hdir; wr_sc |=> O_HSYNC_PIN_OE == $past(I_WDATA[1]); endproperty
  a_hdir: assert property (p_hdir) else $error("h pin enable");
  property p_vdir; wr_sc |=> O_VSYNC_PIN_OE == $past(I_WDATA[3]); endproperty
  a_vdir: assert property (p_vdir) else $error("v pin enable");
  property p_fdir;
    wr_sc |=> O_FRAME_SYNC_PIN_OE == $past(I_WDATA[5]);
  endproperty
  a_fdir: assert property (p_fdir) else $error("f pin enable");
  // enables only move on a sync control write
  property p_oe_hold;
    !wr_sc |=> $stable({O_HSYNC_PIN_OE, O_VSYNC_PIN_OE, O_FRAME_SYNC_PIN_OE});
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
  property p_rb94;
    I_WR && I_ADDR == 8'h94 ##2 I_RD && I_ADDR == 8'h94
      |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  a_rb94: assert property (p_rb94) else $error("upper bits readback");
  property p_rb95;
    I_WR && I_ADDR == 8'h95 ##2 I_RD && I_ADDR == 8'h95
      |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  a_rb95: assert property (p_rb95) else $error("line value readback");
  property p_rb98;
    I_WR && I_ADDR == 8'h98 ##2 I_RD && I_ADDR == 8'h98
      |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  a_rb98: assert property (p_rb98) else $error("line length readback");
  property p_role;
    I_RD && I_ADDR == 8'hA8 |=> O_RDATA[5] == slave_reg && O_RDATA[4:0] == 5'h00;
  endproperty
  a_role: assert property (p_role) else $error("role status");
endmodule // gist_top_checker
bind gist_top gist_top_checker gist_top_checker_inst (.I_CLK(I_CLK),
  .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_HSYNC_PIN_OE(O_HSYNC_PIN_OE),
  .O_VSYNC_PIN_OE(O_VSYNC_PIN_OE), .O_FRAME_SYNC_PIN_OE(O_FRAME_SYNC_PIN_OE));

/* sim/gist_top_tb.sv */
// testbench: registers, master timing and slave sync handling
`timescale 1ns/1ps
module gist_top_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  wire  [7:0] rdata;
  wire        pix, hs_o, hs_oe, vs_o, vs_oe, fs_o, fs_oe, cbr, fld, luma, cursor_interlace_indication;
  wire  [2:0] gfx;
  int         miscompares = 0;
  int         num_checks = 0;
  logic       pl, hs, cb, vs, hs_q, cb_q, vs_q;
  logic [7:0] d;
  always #20 clk = ~clk;
  gist_gfx_model gist_gfx_model_inst (.o_pixel_clock(pix), .o_sync(gfx));
  gist_top gist_top_inst (.I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_PIXEL_CLOCK(pix), .I_HSYNC_PIN(hs_oe ? hs_o : gfx[0]),
    .O_HSYNC_PIN(hs_o), .O_HSYNC_PIN_OE(hs_oe),
    .I_VSYNC_PIN(vs_oe ? vs_o : gfx[1]), .O_VSYNC_PIN(vs_o),
    .O_VSYNC_PIN_OE(vs_oe), .I_FRAME_SYNC_PIN(fs_oe ? fs_o : gfx[2]),
    .O_FRAME_SYNC_PIN(fs_o), .O_FRAME_SYNC_PIN_OE(fs_oe),
    .O_COMPOSITE_BLANKING_REQUEST(cbr), .O_FIELD(fld),
    .O_LUMA_SHARPNESS_ENABLE(luma), .O_CURSOR_INTERLACE_INDICATION(cursor_interlace_indication));
  task chk(input string n, input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task to(input int t);
    if (t >= 5000) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task wrr(input logic [7:0] a, v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task wrc(input logic [7:0] a, v);
    wrr(a, v);
    rdr(a);
    chk("readback", 16'(d), 16'(v));
  endtask
  // active levels, with the output polarity taken out
  task step;
    hs_q = hs;
    cb_q = cb;
    vs_q = vs;
    @(posedge clk);
    #1 hs = hs_o ^ pl;
    cb = cbr ^ pl;
    vs = vs_o ^ pl;
  endtask
  task t_regs;
    logic [7:0] rv [10];
    rv = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'hC7, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rdr(8'h90 + 8'(i));
      chk("reset value", 16'(d), 16'(rv[i]));
    end
    rdr(8'hB0);
    chk("unmapped read", 16'(d), 16'h0000);
    wrc(8'h94, 8'h5A);
    wrc(8'h96, 8'h18);
    chk("ilc luma", 16'({cursor_interlace_indication, luma}), 16'h0003);
    $display("register test done");
  endtask
  task t_master(input logic p);
    logic [15:0] pr [8];
    int t, th, tc, hn, cn, fa, per, hw, off, cw;
    logic f, fq;
    pr = '{16'h9003, 16'h9104, 16'h9201, 16'h9302, 16'h9400, 16'h9503,
           16'h980F, 16'h9900};
    pl = p;
    for (int i = 0; i < 8; i++)
      wrc(pr[i][15:8], pr[i][7:0]);
    wrc(8'h96, {1'b0, p, 6'h00});
    wrc(8'h97, {3'b001, p, 1'b1, p, 1'b1, p});
    t = 0;
    step;
    do begin
      step;
      t++;
    end while (!(vs && !vs_q) && t < 5000);
    to(t);
    repeat (2) begin
      t = 0;
      th = 0;
      hn = hs && !hs_q;
      cn = 0;
      fq = fs_o ^ pl;
      do begin
        step;
        t++;
        if (hs && !hs_q) begin
          per = t - th;
          th = t;
          hn++;
        end
        if (!hs && hs_q)
          hw = t - th;
        if (cb && !cb_q) begin
          if (cn == 0)
            fa = hn;
          if (cn == 0)
            f = fld;
          cn++;
          tc = t;
          off = t - th;
        end
        if (!cb && cb_q)
          cw = t - tc;
      end while (!(vs && !vs_q) && t < 5000);
      to(t);
      chk("line period", 16'(per), 16'd128);
      chk("hsync width", 16'(hw), 16'd64);
      chk("blank offset", 16'(off), 16'd24);
      chk("blank width", 16'(cw), 16'd32);
      chk("blank lines", 16'(cn), 16'd4);
      chk("first line", 16'(fa), f ? 16'd5 : 16'd4);
      chk("frame pin", 16'(fq), 16'(!f));
    end
    $display("master test done");
  endtask
  task pul(input int k, n, input logic [7:0] e, input string s);
    repeat (n) gist_gfx_model_inst.pulse(k);
    rdr(8'hA9);
    chk(s, 16'(d), 16'(e));
  endtask
  task t_slave;
    wrr(8'h97, 8'h00);
    wrr(8'h96, 8'h20);
    rdr(8'hA8);
    chk("role", 16'(d[5]), 16'h0001);
    pul(1, 1, 8'h00, "vsync reset");
    pul(0, 3, 8'h03, "hsync count");
    wrr(8'h97, 8'h40);
    pul(2, 1, 8'h03, "frame ignored");
    pul(1, 1, 8'h00, "vsync fallback");
    wrr(8'h96, 8'hA0);
    pul(0, 2, 8'h02, "hsync count");
    pul(2, 1, 8'h00, "frame as vsync");
    wrr(8'h97, 8'h80);
    pul(2, 2, 8'h02, "frame as hsync");
    wrr(8'h97, 8'h01);
    gist_gfx_model_inst.idle(0, 1'b1);
    pul(0, 1, 8'h03, "falling edge");
    $display("slave test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_master(1'b0);
    t_master(1'b1);
    t_slave;
    tally_and_finish;
  end
endmodule // gist_top_tb

/* verilog/gist_defines.vh */
// register map, field positions, reset values and timing counts
`ifndef GIST_DEFINES_VH
`define GIST_DEFINES_VH

`define GIST_ADDR_HOFS_LO      8'h90
`define GIST_ADDR_HALFPIX_LO   8'h91
`define GIST_ADDR_VOFS_ODD_LO  8'h92
`define GIST_ADDR_VOFS_EVEN_LO 8'h93
`define GIST_ADDR_UPPER_BITS   8'h94
`define GIST_ADDR_REQ_LINE_LO  8'h95
`define GIST_ADDR_MODE_CTRL    8'h96
`define GIST_ADDR_SYNC_CTRL    8'h97
`define GIST_ADDR_LINE_LEN_LO  8'h98
`define GIST_ADDR_LINE_LEN_HI  8'h99
`define GIST_ADDR_STATUS       8'hA8
`define GIST_ADDR_LINE_CNT_LO  8'hA9
`define GIST_ADDR_LINE_CNT_HI  8'hAA

// upper bits register fields
`define GIST_UB_VOFS_EVEN      7:6
`define GIST_UB_VOFS_ODD       5:4
`define GIST_UB_HALFPIX        3:2
`define GIST_UB_HOFS           1:0

// mode control fields
`define GIST_MC_FS_ACCEPT      7
`define GIST_MC_BLANK_POL      6
`define GIST_MC_SLAVE          5
`define GIST_MC_CURSOR_ILC     4
`define GIST_MC_LUMA_SHARP     3
`define GIST_MC_REQ_LINE_HI    1:0

// sync control fields
`define GIST_SC_H_SRC          7
`define GIST_SC_V_SRC          6
`define GIST_SC_F_DIR          5
`define GIST_SC_F_POL          4
`define GIST_SC_V_DIR          3
`define GIST_SC_V_POL          2
`define GIST_SC_H_DIR          1
`define GIST_SC_H_POL          0

// reset values
`define GIST_RST_HOFS          8'h00
`define GIST_RST_HALFPIX       8'h40
`define GIST_RST_VOFS          8'h00
`define GIST_RST_UPPER_BITS    8'h00
`define GIST_RST_REQ_LINE      8'h10
`define GIST_RST_MODE_CTRL     8'h00
`define GIST_RST_SYNC_CTRL     8'h00
`define GIST_RST_LINE_LEN_LO   8'hC7
`define GIST_RST_LINE_LEN_HI   8'h00

// timing counts, in pixel clocks or lines
`define GIST_FIRST_ACTIVE_LINE 12'h002
`define GIST_HSYNC_WIDTH       12'h008
`define GIST_V_TAIL_LINES      12'h004
`define GIST_CNT_MAX           12'hFFF

`endif

/* verilog/gist_sync_in.v */
// three-stage input synchroniser with agree filter and edge pulses
`timescale 1ns/1ps
module gist_sync_in (
  input  wire i_clk,
  input  wire i_reset_n,
  input  wire i_async,
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  wire agree;

  // s1 is read only by s2; the filter looks at s2 and s3
  assign agree  = (s2_reg == s3_reg);
  assign o_rise = agree & s3_reg & ~o_level;
  assign o_fall = agree & ~s3_reg & o_level;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        o_level <= s3_reg;
      end
    end
  end
endmodule // gist_sync_in

/* verilog/gist_top.v */
// graphics input sync timing: registers, sync pins and blanking request
//
// Functional notes
// - upper bits join four low bytes, 10 bits
// - requested lines = value + even off - odd off
// - slave ignores frame sync unless accept set
// - blanking request polarity: 0 high, 1 low active
// - role bit 0 master, 1 slave
// - horizontal sync from pin or frame sync
// - vertical sync from pin or frame sync
// - frame pin direction and polarity bits
// - vertical pin direction and polarity bits
// - horizontal pin direction and polarity bits
// - line length is pixel clocks minus one
// - horizontal offset: hsync to blanking request
// - half pixel count sets request pulse length
// - first active line at field offset plus two
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "gist_defines.vh"
module gist_top (
  input  wire       I_CLK,
  input  wire       I_RESET_N,
  input  wire [7:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  input  wire       I_WR,
  input  wire       I_RD,
  output reg  [7:0] O_RDATA,
  input  wire       I_PIXEL_CLOCK,
  input  wire       I_HSYNC_PIN,
  output reg        O_HSYNC_PIN,
  output wire       O_HSYNC_PIN_OE,
  input  wire       I_VSYNC_PIN,
  output reg        O_VSYNC_PIN,
  output wire       O_VSYNC_PIN_OE,
  input  wire       I_FRAME_SYNC_PIN,
  output reg        O_FRAME_SYNC_PIN,
  output wire       O_FRAME_SYNC_PIN_OE,
  output reg        O_COMPOSITE_BLANKING_REQUEST,
  output reg        O_FIELD,
  output wire       O_LUMA_SHARPNESS_ENABLE,
  output wire       O_CURSOR_INTERLACE_INDICATION
);
  // software registers
  reg [7:0] hofs_lo_reg;
  reg [7:0] halfpix_lo_reg;
  reg [7:0] vofs_odd_lo_reg;
  reg [7:0] vofs_even_lo_reg;
  reg [7:0] upper_bits_reg;
  reg [7:0] req_line_lo_reg;
  reg [7:0] mode_ctrl_reg;
  reg [7:0] sync_ctrl_reg;
  reg [7:0] line_len_lo_reg;
  reg [7:0] line_len_hi_reg;

  // timing state
  reg [11:0] h_cnt_reg;
  reg [11:0] h_cnt_next;
  reg [11:0] v_cnt_reg;
  reg [11:0] v_cnt_next;
  reg        field_reg;
  reg        field_next;
  reg [7:0]  rdata_next;

  // joined 10-bit values, the 12-bit line length and derived line counts
  wire [9:0]  horizontal_offset;
  wire [9:0]  half_active_pixel_count;
  wire [9:0]  odd_field_vertical_offset;
  wire [9:0]  even_field_vertical_offset;
  wire [9:0]  requested_line_value;
  wire [11:0] line_length_value;
  wire [12:0] req_sum;
  wire [11:0] requested_lines;
  wire [11:0] field_vofs;
  wire [11:0] first_active;
  wire [11:0] lines_per_field;

  // control bits
  wire frame_sync_accept;
  wire blanking_request_polarity;
  wire slave_mode;
  wire horizontal_source_select;
  wire vertical_source_select;
  wire frame_pin_polarity;
  wire vertical_pin_polarity;
  wire horizontal_pin_polarity;

  // synchronised pins
  wire pix_rise;
  wire hs_rise;
  wire hs_fall;
  wire vs_rise;
  wire vs_fall;
  wire fs_rise;
  wire fs_fall;
  wire hs_pin_edge;
  wire vs_pin_edge;
  wire fs_pin_edge;
  wire fs_used;
  wire h_edge;
  wire v_edge;
  wire line_end;
  wire field_end;
  wire h_inside;
  wire v_inside;

  assign horizontal_offset          = {upper_bits_reg[`GIST_UB_HOFS],
                                       hofs_lo_reg};
  assign half_active_pixel_count    = {upper_bits_reg[`GIST_UB_HALFPIX],
                                       halfpix_lo_reg};
  assign odd_field_vertical_offset  = {upper_bits_reg[`GIST_UB_VOFS_ODD],
                                       vofs_odd_lo_reg};
  assign even_field_vertical_offset = {upper_bits_reg[`GIST_UB_VOFS_EVEN],
                                       vofs_even_lo_reg};
  assign requested_line_value       = {mode_ctrl_reg[`GIST_MC_REQ_LINE_HI],
                                       req_line_lo_reg};
  assign line_length_value = {line_len_hi_reg[3:0],
                              line_len_lo_reg};

  // a negative difference is a programming error; request no lines then
  assign req_sum = {3'h0, requested_line_value} +
                   {3'h0, even_field_vertical_offset} -
                   {3'h0, odd_field_vertical_offset};
  assign requested_lines = req_sum[12] ? 12'h000 : req_sum[11:0];

  assign field_vofs   = field_reg ? {2'h0, even_field_vertical_offset}
                                  : {2'h0, odd_field_vertical_offset};
  assign first_active = field_vofs + `GIST_FIRST_ACTIVE_LINE;
  assign lines_per_field = first_active + requested_lines +
                           `GIST_V_TAIL_LINES;

  assign frame_sync_accept         = mode_ctrl_reg[`GIST_MC_FS_ACCEPT];
  assign blanking_request_polarity = mode_ctrl_reg[`GIST_MC_BLANK_POL];
  assign slave_mode                = mode_ctrl_reg[`GIST_MC_SLAVE];
  assign horizontal_source_select  = sync_ctrl_reg[`GIST_SC_H_SRC];
  assign vertical_source_select    = sync_ctrl_reg[`GIST_SC_V_SRC];
  assign frame_pin_polarity        = sync_ctrl_reg[`GIST_SC_F_POL];
  assign vertical_pin_polarity     = sync_ctrl_reg[`GIST_SC_V_POL];
  assign horizontal_pin_polarity   = sync_ctrl_reg[`GIST_SC_H_POL];

  assign O_HSYNC_PIN_OE      = sync_ctrl_reg[`GIST_SC_H_DIR];
  assign O_VSYNC_PIN_OE      = sync_ctrl_reg[`GIST_SC_V_DIR];
  assign O_FRAME_SYNC_PIN_OE = sync_ctrl_reg[`GIST_SC_F_DIR];
  assign O_LUMA_SHARPNESS_ENABLE       = mode_ctrl_reg[`GIST_MC_LUMA_SHARP];
  assign O_CURSOR_INTERLACE_INDICATION = mode_ctrl_reg[`GIST_MC_CURSOR_ILC];

  // the pixel clock is sampled, so it must stay well below half I_CLK
  gist_sync_in u_pix (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   (I_PIXEL_CLOCK),
    .o_level   (),
    .o_rise    (pix_rise),
    .o_fall    ()
  );

  gist_sync_in u_hs (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   (I_HSYNC_PIN),
    .o_level   (),
    .o_rise    (hs_rise),
    .o_fall    (hs_fall)
  );

  gist_sync_in u_vs (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   (I_VSYNC_PIN),
    .o_level   (),
    .o_rise    (vs_rise),
    .o_fall    (vs_fall)
  );

  gist_sync_in u_fs (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   (I_FRAME_SYNC_PIN),
    .o_level   (),
    .o_rise    (fs_rise),
    .o_fall    (fs_fall)
  );

  // a pin driven as output is never taken as a sync source
  assign hs_pin_edge = ~O_HSYNC_PIN_OE &
    (horizontal_pin_polarity ? hs_fall : hs_rise);
  assign vs_pin_edge = ~O_VSYNC_PIN_OE &
    (vertical_pin_polarity ? vs_fall : vs_rise);
  assign fs_pin_edge = ~O_FRAME_SYNC_PIN_OE &
    (frame_pin_polarity ? fs_fall : fs_rise);
  assign fs_used = slave_mode & frame_sync_accept & fs_pin_edge;

  // without accept the select bit falls back to the sync pin itself
  assign h_edge = slave_mode &
    ((horizontal_source_select & frame_sync_accept) ? fs_pin_edge
                                                   : hs_pin_edge);
  assign v_edge = slave_mode &
    ((vertical_source_select & frame_sync_accept) ? fs_pin_edge
                                                 : vs_pin_edge);

  assign line_end  = ~slave_mode & pix_rise &
                     (h_cnt_reg >= line_length_value);
  assign field_end = line_end & (v_cnt_reg + 12'h001 >= lines_per_field);

  gist_window u_hwin (
    .i_count  (h_cnt_reg),
    .i_start  ({2'h0, horizontal_offset}),
    .i_length ({2'h0, half_active_pixel_count}),
    .o_inside (h_inside)
  );

  gist_window u_vwin (
    .i_count  (v_cnt_reg),
    .i_start  (first_active),
    .i_length (requested_lines),
    .o_inside (v_inside)
  );

  // counters: free running in master, edge restarted in slave
  always @* begin
    h_cnt_next = h_cnt_reg;
    v_cnt_next = v_cnt_reg;
    field_next = field_reg;
    if (h_edge) begin
      h_cnt_next = 12'h000;
      if (v_cnt_reg != `GIST_CNT_MAX) begin
        v_cnt_next = v_cnt_reg + 12'h001;
      end
    end else if (line_end) begin
      h_cnt_next = 12'h000;
      v_cnt_next = field_end ? 12'h000 : v_cnt_reg + 12'h001;
      field_next = field_end ? ~field_reg : field_reg;
    end else if (pix_rise && h_cnt_reg != `GIST_CNT_MAX) begin
      h_cnt_next = h_cnt_reg + 12'h001;
    end
    if (v_edge) begin
      v_cnt_next = 12'h000;
      // a frame sync marks the odd field; otherwise fields alternate
      field_next = fs_used ? 1'b0 : ~field_reg;
    end else if (fs_used) begin
      field_next = 1'b0;
    end
  end

  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      h_cnt_reg <= 12'h000;
      v_cnt_reg <= 12'h000;
      field_reg <= 1'b0;
      O_HSYNC_PIN <= 1'b0;
      O_VSYNC_PIN <= 1'b0;
      O_FRAME_SYNC_PIN <= 1'b0;
      O_COMPOSITE_BLANKING_REQUEST <= 1'b0;
      O_FIELD <= 1'b0;
    end else begin
      h_cnt_reg <= h_cnt_next;
      v_cnt_reg <= v_cnt_next;
      field_reg <= field_next;
      O_FIELD   <= field_reg;
      O_HSYNC_PIN <= horizontal_pin_polarity ^
        (h_cnt_reg < `GIST_HSYNC_WIDTH);
      O_VSYNC_PIN <= vertical_pin_polarity ^
        (v_cnt_reg == 12'h000);
      O_FRAME_SYNC_PIN <= frame_pin_polarity ^
        ((v_cnt_reg == 12'h000) & ~field_reg);
      O_COMPOSITE_BLANKING_REQUEST <= blanking_request_polarity ^
        (h_inside & v_inside);
    end
  end

  // register writes; bit 2 of mode control is stored as written
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      hofs_lo_reg      <= `GIST_RST_HOFS;
      halfpix_lo_reg   <= `GIST_RST_HALFPIX;
      vofs_odd_lo_reg  <= `GIST_RST_VOFS;
      vofs_even_lo_reg <= `GIST_RST_VOFS;
      upper_bits_reg   <= `GIST_RST_UPPER_BITS;
      req_line_lo_reg  <= `GIST_RST_REQ_LINE;
      mode_ctrl_reg    <= `GIST_RST_MODE_CTRL;
      sync_ctrl_reg    <= `GIST_RST_SYNC_CTRL;
      line_len_lo_reg  <= `GIST_RST_LINE_LEN_LO;
      line_len_hi_reg  <= `GIST_RST_LINE_LEN_HI;
    end else if (I_WR) begin
      case (I_ADDR)
        `GIST_ADDR_HOFS_LO:      hofs_lo_reg      <= I_WDATA;
        `GIST_ADDR_HALFPIX_LO:   halfpix_lo_reg   <= I_WDATA;
        `GIST_ADDR_VOFS_ODD_LO:  vofs_odd_lo_reg  <= I_WDATA;
        `GIST_ADDR_VOFS_EVEN_LO: vofs_even_lo_reg <= I_WDATA;
        `GIST_ADDR_UPPER_BITS:   upper_bits_reg   <= I_WDATA;
        `GIST_ADDR_REQ_LINE_LO:  req_line_lo_reg  <= I_WDATA;
        `GIST_ADDR_MODE_CTRL:    mode_ctrl_reg    <= I_WDATA;
        `GIST_ADDR_SYNC_CTRL:    sync_ctrl_reg    <= I_WDATA;
        `GIST_ADDR_LINE_LEN_LO:  line_len_lo_reg  <= I_WDATA;
        `GIST_ADDR_LINE_LEN_HI:  line_len_hi_reg  <= I_WDATA;
        default: ;
      endcase
    end
  end

  always @* begin
    case (I_ADDR)
      `GIST_ADDR_HOFS_LO:      rdata_next = hofs_lo_reg;
      `GIST_ADDR_HALFPIX_LO:   rdata_next = halfpix_lo_reg;
      `GIST_ADDR_VOFS_ODD_LO:  rdata_next = vofs_odd_lo_reg;
      `GIST_ADDR_VOFS_EVEN_LO: rdata_next = vofs_even_lo_reg;
      `GIST_ADDR_UPPER_BITS:   rdata_next = upper_bits_reg;
      `GIST_ADDR_REQ_LINE_LO:  rdata_next = req_line_lo_reg;
      `GIST_ADDR_MODE_CTRL:    rdata_next = mode_ctrl_reg;
      `GIST_ADDR_SYNC_CTRL:    rdata_next = sync_ctrl_reg;
      `GIST_ADDR_LINE_LEN_LO:  rdata_next = line_len_lo_reg;
      `GIST_ADDR_LINE_LEN_HI:  rdata_next = line_len_hi_reg;
      `GIST_ADDR_STATUS:
        rdata_next = {field_reg, h_inside & v_inside, slave_mode, 5'h00};
      `GIST_ADDR_LINE_CNT_LO:  rdata_next = v_cnt_reg[7:0];
      `GIST_ADDR_LINE_CNT_HI:  rdata_next = {4'h0, v_cnt_reg[11:8]};
      default:                 rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= I_RD ? rdata_next : 8'h00;
    end
  end
endmodule // gist_top

/* verilog/gist_window.v */
// window compare: count lies in [start, start + length)
`timescale 1ns/1ps
module gist_window (
  input  wire [11:0] i_count,
  input  wire [11:0] i_start,
  input  wire [11:0] i_length,
  output wire        o_inside
);
  wire [12:0] stop;

  // one extra bit keeps a window near the top from wrapping to empty
  assign stop     = {1'b0, i_start} + {1'b0, i_length};
  assign o_inside = (i_count >= i_start) &&
                    ({1'b0, i_count} < stop);
endmodule // gist_window
